// ==== startup_parser_defs.vh ====
/*
 * Constants for the serial connect startup parser: connect-mode field
 * layout, startup selections, command characters, response characters.
 * Assumes inclusion by bare name from design files; definitions only.
 */
`ifndef STARTUP_PARSER_DEFS_VH
`define STARTUP_PARSER_DEFS_VH

// connect-mode configuration byte layout
`define CM_RESP_BIT       4
`define CM_START_HI       3
`define CM_START_LO       0
`define CM_RESET_VAL      8'hC0

// startup selections, including no startup
`define ST_NONE           4'h0
`define ST_ANY_CHAR       4'h1
`define ST_CTRL_IN        4'h2
`define ST_START_CHAR     4'h3
`define ST_MANUAL         4'h4

// characters
`define CH_CMD            8'h43
`define CH_CR             8'h0D
`define CH_LF             8'h0A
`define CH_DOT            8'h2E
`define CH_SLASH          8'h2F
`define CH_ZERO           8'h30
`define CH_NINE           8'h39
`define CH_DEFAULT_START  8'h0D

// connection-state responses
`define RSP_CONN          8'h43
`define RSP_DISC          8'h44
`define RSP_UNREACH       8'h4E

// connection state codes from the network engine
`define CS_DISC           2'h0
`define CS_CONN           2'h1
`define CS_UNREACH        2'h2

// parser limits
`define MAX_ADDR_BYTES    3'h4
`define MAX_BYTE_VAL      10'h0FF
`define MAX_PORT_VAL      17'h0FFFF

`endif

// ==== decimal_accum.v ====
/*
 * Decimal field accumulator: multiplies the running value by ten and adds
 * one digit. Flags overflow past the given limit.
 * Assumes digits 0..9 arrive only while the caller is inside a number field.
 */
`timescale 1ns/100ps
module decimal_accum (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // control
  input  wire        clear_in,
  input  wire        digit_valid_in,
  input  wire [3:0]  digit_in,
  input  wire [16:0] limit_in,
  // result
  output reg  [16:0] value_out,
  output reg         over_out,
  output reg         seen_out
);

  wire [20:0] next_val;

  assign next_val = {1'b0, value_out, 3'h0} + {3'h0, value_out, 1'b0}
                    + {17'h0, digit_in};

  always @(posedge clk_in) begin
    if (rst_in || clear_in) begin
      value_out <= 17'h0;
      over_out  <= 1'b0;
      seen_out  <= 1'b0;
    end else if (digit_valid_in) begin
      seen_out <= 1'b1;
      if (next_val > {4'h0, limit_in}) begin
        over_out <= 1'b1;
      end else begin
        value_out <= next_val[16:0];
      end
    end
  end

endmodule // decimal_accum

// ==== serial_connect_startup_parser.v ====
/*
 * Serial connect startup parser: decides when an outgoing connection is
 * started from serial activity, parses manual connect commands and sends
 * connection-state characters. Assumes one clock, characters arrive as
 * one-cycle strobes and the network engine reports state as a level.
 */
`timescale 1ns/100ps
`include "startup_parser_defs.vh"

// Operation
// - send C, D or N on state change
// - suppress responses in modem or hostlist modes
// - reset defaults response option to quiet
// - no-startup setting never starts a connection
// - any character starts a connection
// - control input rising edge starts a connection
// - start character starts; default carriage return
// - dot-decimal address of 1 to 4 bytes
// - optional slash then port 1 to 65535
// - missing port uses stored remote port
// - partial address fills low bytes only
// - all-zero address and port enters monitor mode
module serial_connect_startup_parser (
  // clock and reset
  input  wire        clk_in,
  input  wire        rst_in,
  // configuration
  input  wire        cfg_load_in,
  input  wire [7:0]  cfg_mode_in,
  input  wire [7:0]  cfg_start_char_in,
  input  wire        cfg_modem_active_in,
  input  wire        cfg_hostlist_active_in,
  input  wire [31:0] stored_ip_in,
  input  wire [15:0] stored_port_in,
  // serial side
  input  wire        rx_valid_in,
  input  wire [7:0]  rx_char_in,
  input  wire        ctrl_in,
  output reg         tx_valid_out,
  output reg  [7:0]  tx_char_out,
  // network engine
  input  wire [1:0]  conn_state_in,
  output reg         connect_out,
  output reg  [31:0] connect_ip_out,
  output reg  [15:0] connect_port_out,
  output reg         monitor_out,
  output reg         cmd_error_out,
  output reg  [7:0]  cfg_mode_out
);

  localparam [3:0] P_IDLE = 4'h1;
  localparam [3:0] P_ADDR = 4'h2;
  localparam [3:0] P_PORT = 4'h4;
  localparam [3:0] P_SKIP = 4'h8;

  reg  [7:0]  mode_q;
  reg  [7:0]  start_char_q;
  reg  [3:0]  pstate_q;
  reg  [3:0]  pstate_d;
  reg  [31:0] addr_q;
  reg  [2:0]  nbytes_q;
  reg         ctrl_q;
  reg  [1:0]  cs_q;
  reg         acc_clear;
  reg         byte_push;
  reg         finish;
  reg         bad;

  wire [3:0]  start_sel;
  wire        is_digit;
  wire        is_term;
  wire [16:0] acc_val;
  wire        acc_over;
  wire        acc_seen;
  wire [16:0] acc_limit;
  wire [31:0] merged_ip;
  wire [31:0] addr_next;
  wire        digit_strobe;

  assign start_sel = mode_q[`CM_START_HI:`CM_START_LO];
  assign is_digit  = (rx_char_in >= `CH_ZERO) && (rx_char_in <= `CH_NINE);
  assign is_term   = (rx_char_in == `CH_CR) || (rx_char_in == `CH_LF);
  assign acc_limit = (pstate_q == P_PORT) ? `MAX_PORT_VAL
                                          : {7'h0, `MAX_BYTE_VAL};
  assign digit_strobe = rx_valid_in && is_digit && (start_sel == `ST_MANUAL)
                        && ((pstate_q == P_ADDR) || (pstate_q == P_PORT));
  assign addr_next = {addr_q[23:0], acc_val[7:0]};

  // per-byte merge of parsed low bytes into stored address
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_merge
      assign merged_ip[gi*8 +: 8] = (gi < nbytes_q) ? addr_q[gi*8 +: 8]
                                                     : stored_ip_in[gi*8 +: 8];
    end
  endgenerate

  decimal_accum u_acc (
    .clk_in         (clk_in),
    .rst_in         (rst_in),
    .clear_in       (acc_clear),
    .digit_valid_in (digit_strobe),
    .digit_in       (rx_char_in[3:0]),
    .limit_in       (acc_limit),
    .value_out      (acc_val),
    .over_out       (acc_over),
    .seen_out       (acc_seen)
  );

  // configuration store
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_q       <= `CM_RESET_VAL;
      start_char_q <= `CH_DEFAULT_START;
    end else if (cfg_load_in) begin
      mode_q       <= cfg_mode_in;
      start_char_q <= cfg_start_char_in;
    end
  end

  // manual command parser next state
  always @* begin
    pstate_d  = pstate_q;
    acc_clear = 1'b0;
    byte_push = 1'b0;
    finish    = 1'b0;
    bad       = 1'b0;
    if (rx_valid_in && (start_sel == `ST_MANUAL)) begin
      case (pstate_q)
        P_IDLE: begin
          if (rx_char_in == `CH_CMD) begin
            pstate_d  = P_ADDR;
            acc_clear = 1'b1;
          end
        end
        P_ADDR: begin
          if (is_digit) begin
            pstate_d = P_ADDR;
          end else if (rx_char_in == `CH_DOT) begin
            if (!acc_seen || acc_over ||
                nbytes_q >= `MAX_ADDR_BYTES - 3'h1) begin
              bad = 1'b1;
            end else begin
              byte_push = 1'b1;
              acc_clear = 1'b1;
            end
          end else if (rx_char_in == `CH_SLASH) begin
            if (!acc_seen || acc_over) begin
              bad = 1'b1;
            end else begin
              byte_push = 1'b1;
              acc_clear = 1'b1;
              pstate_d  = P_PORT;
            end
          end else if (is_term) begin
            if (!acc_seen || acc_over) begin
              bad = 1'b1;
            end else begin
              byte_push = 1'b1;
              finish    = 1'b1;
            end
          end else begin
            bad = 1'b1;
          end
        end
        P_PORT: begin
          if (is_term) begin
            if (!acc_seen || acc_over) begin
              bad = 1'b1;
            end else begin
              finish = 1'b1;
            end
          end else if (!is_digit) begin
            bad = 1'b1;
          end
        end
        P_SKIP: begin
          if (is_term) begin
            pstate_d = P_IDLE;
          end
        end
        default: pstate_d = P_IDLE;
      endcase
      if (finish) begin
        pstate_d = P_IDLE;
      end
      if (bad) begin
        pstate_d = is_term ? P_IDLE : P_SKIP;
      end
    end
  end

  // parser registers
  always @(posedge clk_in) begin
    if (rst_in || start_sel != `ST_MANUAL) begin
      pstate_q <= P_IDLE;
      addr_q   <= 32'h0;
      nbytes_q <= 3'h0;
    end else begin
      pstate_q <= pstate_d;
      if (rx_valid_in && pstate_q == P_IDLE && rx_char_in == `CH_CMD) begin
        addr_q   <= 32'h0;
        nbytes_q <= 3'h0;
      end else if (byte_push) begin
        addr_q   <= addr_next;
        nbytes_q <= nbytes_q + 3'h1;
      end
    end
  end

  // connection start decisions
  always @(posedge clk_in) begin
    if (rst_in) begin
      ctrl_q           <= 1'b0;
      connect_out      <= 1'b0;
      connect_ip_out   <= 32'h0;
      connect_port_out <= 16'h0;
      monitor_out      <= 1'b0;
      cmd_error_out    <= 1'b0;
    end else begin
      ctrl_q        <= ctrl_in;
      connect_out   <= 1'b0;
      monitor_out   <= 1'b0;
      cmd_error_out <= bad;
      case (start_sel)
        `ST_ANY_CHAR: begin
          if (rx_valid_in) begin
            connect_out      <= 1'b1;
            connect_ip_out   <= stored_ip_in;
            connect_port_out <= stored_port_in;
          end
        end
        `ST_CTRL_IN: begin
          if (ctrl_in && !ctrl_q) begin
            connect_out      <= 1'b1;
            connect_ip_out   <= stored_ip_in;
            connect_port_out <= stored_port_in;
          end
        end
        `ST_START_CHAR: begin
          if (rx_valid_in && rx_char_in == start_char_q) begin
            connect_out      <= 1'b1;
            connect_ip_out   <= stored_ip_in;
            connect_port_out <= stored_port_in;
          end
        end
        `ST_MANUAL: begin
          if (finish) begin
            if (pstate_q == P_PORT && acc_val == 17'h0) begin
              if (nbytes_q == `MAX_ADDR_BYTES && addr_q == 32'h0) begin
                monitor_out <= 1'b1;
              end else begin
                cmd_error_out <= 1'b1;
              end
            end else begin
              connect_out    <= 1'b1;
              connect_ip_out <= (pstate_q == P_ADDR)
                ? ((nbytes_q == 3'h3) ? addr_next
                   : (nbytes_q == 3'h2) ? {stored_ip_in[31:24], addr_next[23:0]}
                   : (nbytes_q == 3'h1) ? {stored_ip_in[31:16], addr_next[15:0]}
                   : {stored_ip_in[31:8], addr_next[7:0]})
                : merged_ip;
              connect_port_out <= (pstate_q == P_PORT) ? acc_val[15:0]
                                                       : stored_port_in;
            end
          end
        end
        default: ;
      endcase
    end
  end

  // connection-state character responses
  always @(posedge clk_in) begin
    if (rst_in) begin
      cs_q         <= `CS_DISC;
      tx_valid_out <= 1'b0;
      tx_char_out  <= 8'h00;
      cfg_mode_out <= `CM_RESET_VAL;
    end else begin
      cs_q         <= conn_state_in;
      cfg_mode_out <= mode_q;
      tx_valid_out <= 1'b0;
      if (conn_state_in != cs_q && mode_q[`CM_RESP_BIT] &&
          !cfg_modem_active_in && !cfg_hostlist_active_in) begin
        tx_valid_out <= 1'b1;
        case (conn_state_in)
          `CS_CONN:    tx_char_out <= `RSP_CONN;
          `CS_UNREACH: tx_char_out <= `RSP_UNREACH;
          default:     tx_char_out <= `RSP_DISC;
        endcase
      end
    end
  end

endmodule // serial_connect_startup_parser

// ==== startup_parser_props.sv ====
/* Assertions for the serial connect startup parser.
   Sees only the top module ports; bound to it below. */
`timescale 1ns/100ps
module startup_parser_props (
  // clock and reset
  input logic        clk_in,
  input logic        rst_in,
  // inputs
  input logic        rx_valid_in,
  input logic [7:0]  rx_char_in,
  input logic        ctrl_in,
  input logic [1:0]  conn_state_in,
  input logic        cfg_modem_active_in,
  input logic        cfg_hostlist_active_in,
  input logic [31:0] stored_ip_in,
  input logic [15:0] stored_port_in,
  // outputs
  input logic        tx_valid_out,
  input logic [7:0]  tx_char_out,
  input logic        connect_out,
  input logic [31:0] connect_ip_out,
  input logic [15:0] connect_port_out,
  input logic        monitor_out,
  input logic [7:0]  cfg_mode_out
);
  wire [3:0] sel = cfg_mode_out[3:0];
  wire       rsp = cfg_mode_out[4];
  wire       term = rx_valid_in &&
                    (rx_char_in == 8'h0D || rx_char_in == 8'h0A);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_any_start: assert property (
    rx_valid_in && sel == 4'h1 ##1 sel == 4'h1 |-> connect_out)
    else $error("no connect after character");
  chk_none_idle: assert property (
    (sel == 4'h0)[*2] |-> !connect_out)
    else $error("connect with no startup");
  chk_ctrl_rise: assert property (
    $rose(ctrl_in) && sel == 4'h2 ##1 sel == 4'h2 |-> connect_out)
    else $error("no connect on control rise");
  chk_ctrl_level: assert property (
    (ctrl_in && sel == 4'h2)[*3] |-> !connect_out)
    else $error("connect on steady control");
  chk_stored_dest: assert property (
    (sel != 4'h4)[*2] ##0 connect_out |->
    connect_ip_out == stored_ip_in && connect_port_out == stored_port_in)
    else $error("wrong stored destination");
  chk_manual_term: assert property (
    (sel == 4'h4 && !term)[*2] |-> !connect_out && !monitor_out)
    else $error("manual result without terminator");
  chk_resp_char: assert property (
    conn_state_in != $past(conn_state_in) && rsp && !cfg_modem_active_in
    && !cfg_hostlist_active_in ##1 rsp |-> tx_valid_out &&
    tx_char_out == ($past(conn_state_in) == 2'h1 ? 8'h43 :
    $past(conn_state_in) == 2'h2 ? 8'h4E : 8'h44))
    else $error("missing or wrong response");
  chk_resp_quiet: assert property (
    (!rsp)[*2] |-> !tx_valid_out)
    else $error("response while quiet");
  chk_resp_block: assert property (
    $past(cfg_modem_active_in || cfg_hostlist_active_in) |-> !tx_valid_out)
    else $error("response while suppressed");
  cover property (connect_out);
  cover property (monitor_out);
  cover property (tx_valid_out && tx_char_out == 8'h4E);
endmodule // startup_parser_props

bind serial_connect_startup_parser startup_parser_props
  startup_parser_props_i (
  .clk_in(clk_in), .rst_in(rst_in), .rx_valid_in(rx_valid_in),
  .rx_char_in(rx_char_in), .ctrl_in(ctrl_in),
  .conn_state_in(conn_state_in),
  .cfg_modem_active_in(cfg_modem_active_in),
  .cfg_hostlist_active_in(cfg_hostlist_active_in),
  .stored_ip_in(stored_ip_in), .stored_port_in(stored_port_in),
  .tx_valid_out(tx_valid_out), .tx_char_out(tx_char_out),
  .connect_out(connect_out), .connect_ip_out(connect_ip_out),
  .connect_port_out(connect_port_out), .monitor_out(monitor_out),
  .cfg_mode_out(cfg_mode_out));

// ==== serial_dev.sv ====
/* Model of the attached serial device: one-cycle character strobes
   and the control input. Assumes the parser clock. */
`timescale 1ns/100ps
module serial_dev (
  // clock
  input  logic       clk_in,
  // serial side
  output logic       rx_valid_out,
  output logic [7:0] rx_char_out,
  output logic       ctrl_out
);
  initial begin
    rx_valid_out = 1'b0;
    rx_char_out  = 8'hFF;
    ctrl_out     = 1'b0;
  end
  task send(input logic [7:0] c);
    @(posedge clk_in);
    rx_valid_out <= 1'b1;
    rx_char_out  <= c;
    @(posedge clk_in);
    rx_valid_out <= 1'b0;
    // idle data is never a stale copy
    rx_char_out  <= ~c;
  endtask
  task send_cmd(input string body, input logic [7:0] term);
    int i;
    send(8'h43);
    for (i = 0; i < body.len(); i++)
      send(body[i]);
    send(term);
  endtask
  task set_ctrl(input logic v);
    @(posedge clk_in);
    ctrl_out <= v;
  endtask
endmodule // serial_dev

// ==== tb_serial_connect_startup_parser.sv ====
/* Testbench for the serial connect startup parser: startup modes,
   manual commands, state responses. Assumes the serial_dev model. */
`timescale 1ns/100ps
module tb_serial_connect_startup_parser;
  localparam logic [31:0] ip_st = 32'h81010203;
  localparam logic [15:0] pt_st = 16'h04D2;
  logic clk_in, rst_in, cfg_load_in, ctrl_in, rx_valid_in;
  logic cfg_modem_active_in, cfg_hostlist_active_in;
  logic tx_valid_out, connect_out, monitor_out, cmd_error_out;
  logic [7:0]  cfg_mode_in, cfg_start_char_in, rx_char_in;
  logic [7:0]  tx_char_out, cfg_mode_out, got_tx;
  logic [1:0]  conn_state_in;
  logic [31:0] stored_ip_in, connect_ip_out, got_ip;
  logic [15:0] stored_port_in, connect_port_out, got_pt;
  int fail_count, num_checks, n_conn, n_mon, n_err, n_tx, i;
  serial_connect_startup_parser serial_connect_startup_parser_i (
    .clk_in(clk_in), .rst_in(rst_in), .cfg_load_in(cfg_load_in),
    .cfg_mode_in(cfg_mode_in), .cfg_start_char_in(cfg_start_char_in),
    .cfg_modem_active_in(cfg_modem_active_in),
    .cfg_hostlist_active_in(cfg_hostlist_active_in),
    .stored_ip_in(stored_ip_in), .stored_port_in(stored_port_in),
    .rx_valid_in(rx_valid_in), .rx_char_in(rx_char_in), .ctrl_in(ctrl_in),
    .tx_valid_out(tx_valid_out), .tx_char_out(tx_char_out),
    .conn_state_in(conn_state_in), .connect_out(connect_out),
    .connect_ip_out(connect_ip_out), .connect_port_out(connect_port_out),
    .monitor_out(monitor_out), .cmd_error_out(cmd_error_out),
    .cfg_mode_out(cfg_mode_out));
  serial_dev serial_dev_i (.clk_in(clk_in), .rx_valid_out(rx_valid_in),
    .rx_char_out(rx_char_in), .ctrl_out(ctrl_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (connect_out === 1'b1) begin
      n_conn++;
      got_ip = connect_ip_out;
      got_pt = connect_port_out;
    end
    if (monitor_out === 1'b1) n_mon++;
    if (cmd_error_out === 1'b1) n_err++;
    if (tx_valid_out === 1'b1) begin
      n_tx++;
      got_tx = tx_char_out;
    end
  end
  task stop_test;
    if (fail_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task clr;
    n_conn = 0;
    n_mon = 0;
    n_err = 0;
    n_tx = 0;
  endtask
  task expect_n(input int c, input int m, input int e, input int t);
    repeat (4) @(posedge clk_in);
    @(negedge clk_in);
    check(n_conn, c);
    check(n_mon, m);
    check(n_err != 0, e);
    check(n_tx, t);
    clr();
  endtask
  task load(input logic [7:0] m, input logic [7:0] sc);
    @(posedge clk_in);
    cfg_mode_in <= m;
    cfg_start_char_in <= sc;
    cfg_load_in <= 1'b1;
    @(posedge clk_in);
    cfg_load_in <= 1'b0;
    expect_n(0, 0, 0, 0);
  endtask
  task t_defaults;
    check(cfg_mode_out, 8'hC0);
    serial_dev_i.send(8'h0D);
    serial_dev_i.set_ctrl(1'b1);
    serial_dev_i.set_ctrl(1'b0);
    @(posedge clk_in);
    conn_state_in <= 2'h1;
    expect_n(0, 0, 0, 0);
  endtask
  task t_startups;
    load(8'h01, 8'h0D);
    serial_dev_i.send(8'h7A);
    serial_dev_i.send(8'h00);
    serial_dev_i.set_ctrl(1'b1);
    serial_dev_i.set_ctrl(1'b0);
    expect_n(2, 0, 0, 0);
    check(got_ip, ip_st);
    check(got_pt, pt_st);
    load(8'h02, 8'h0D);
    serial_dev_i.send(8'h7A);
    serial_dev_i.set_ctrl(1'b1);
    repeat (4) @(posedge clk_in);
    serial_dev_i.set_ctrl(1'b0);
    expect_n(1, 0, 0, 0);
    load(8'h03, 8'h41);
    serial_dev_i.send(8'h42);
    serial_dev_i.send(8'h0D);
    serial_dev_i.send(8'h41);
    expect_n(1, 0, 0, 0);
  endtask
  task t_manual;
    load(8'h04, 8'h0D);
    serial_dev_i.send_cmd("5", 8'h0D);
    expect_n(1, 0, 0, 0);
    check(got_ip, {ip_st[31:8], 8'h05});
    check(got_pt, pt_st);
    serial_dev_i.send_cmd("28.10/12", 8'h0A);
    expect_n(1, 0, 0, 0);
    check(got_ip, {ip_st[31:16], 16'h1C0A});
    check(got_pt, 16'h000C);
    serial_dev_i.send_cmd("121.2.4.5/65535", 8'h0D);
    expect_n(1, 0, 0, 0);
    check(got_ip, 32'h79020405);
    check(got_pt, 16'hFFFF);
    serial_dev_i.send_cmd("0.0.0.0/0", 8'h0D);
    expect_n(0, 1, 0, 0);
    serial_dev_i.send_cmd("1 2", 8'h0D);
    expect_n(0, 0, 1, 0);
    serial_dev_i.send_cmd("256", 8'h0D);
    expect_n(0, 0, 1, 0);
    serial_dev_i.send_cmd("1/65536", 8'h0A);
    expect_n(0, 0, 1, 0);
    serial_dev_i.send_cmd("5/0", 8'h0D);
    expect_n(0, 0, 1, 0);
    serial_dev_i.send_cmd("1.2.3.4.5", 8'h0A);
    expect_n(0, 0, 1, 0);
    @(posedge clk_in);
    stored_ip_in <= 32'hC0A80A14;
    stored_port_in <= 16'h1F90;
    serial_dev_i.send_cmd("7", 8'h0D);
    expect_n(1, 0, 0, 0);
    check(got_ip, 32'hC0A80A07);
    check(got_pt, 16'h1F90);
  endtask
  task t_resp;
    logic [1:0] st[3];
    logic [7:0] ch[3];
    st = '{2'h2, 2'h0, 2'h1};
    ch = '{8'h4E, 8'h44, 8'h43};
    load(8'h10, 8'h0D);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_in);
      conn_state_in <= st[i];
      expect_n(0, 0, 0, 1);
      check(got_tx, ch[i]);
    end
    @(posedge clk_in);
    cfg_modem_active_in <= 1'b1;
    conn_state_in <= 2'h2;
    @(posedge clk_in);
    cfg_modem_active_in <= 1'b0;
    cfg_hostlist_active_in <= 1'b1;
    conn_state_in <= 2'h0;
    @(posedge clk_in);
    cfg_hostlist_active_in <= 1'b0;
    expect_n(0, 0, 0, 0);
  endtask
  initial begin
    #100000;
    fail_count++;
    stop_test();
  end
  initial begin
    rst_in = 1'b1;
    cfg_load_in = 1'b0;
    cfg_mode_in = 8'h00;
    cfg_start_char_in = 8'h00;
    cfg_modem_active_in = 1'b0;
    cfg_hostlist_active_in = 1'b0;
    stored_ip_in = ip_st;
    stored_port_in = pt_st;
    conn_state_in = 2'h0;
    fail_count = 0;
    num_checks = 0;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    @(negedge clk_in);
    clr();
    t_defaults();
    t_startups();
    t_manual();
    t_resp();
    stop_test();
  end
endmodule // tb_serial_connect_startup_parser
